// ---- rtl/counter_latch_retrigger_capture.sv ----
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Edge select picks rising, falling or both edges of the trigger.
// - Captures act only once the software gate enable has been set.
// - Retrigger: opening gate keeps values; first edge starts at load.
// - Retrigger: each later edge reloads the counter and counting goes on.
// - Captured value is the count present when the edge is seen.
// - Trigger input level is readable as a status flag.
// - Last captured count is readable.
// - Retrigger: closing gate pauses, reopening resumes from last count.
// - Retrigger, gate closed: edge still captures and reloads.
// - Gate-stop ends counting and further captures.
// - Latch-only: capture never alters count; opening starts at load.
// - Latch-only: closing gate cancels; next opening restarts at load.
// - Latch-only, gate closed: edge captures, count unchanged.
// - Optional interrupt on every capture in all three modes.
// - Capture while interrupt unacknowledged still overwrites the latch and is flagged.
// - Interval mode counts the internal 1 MHz time base.
// - Interval: first edge starts timing, later edges store microseconds.
// - Interval edges follow the rising, falling or both setting.
module counter_latch_retrigger_capture
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic capture_trigger_input,
  input wire logic count_pulse,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  output logic diag_irq
);
  logic [2:0] sync_r;
  logic [31:0] count_r, count_nxt;
  logic [31:0] latch_r, latch_nxt;
  logic [31:0] load_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic gate_r, irq_en_r, stopped_r, armed_r, irq_r, lost_r, diag_r;
  logic [1:0] edge_r, mode_r;
  logic [4:0] tb_cnt_r;
  logic lvl, rise, fall, edge_hit, tick, run, capture;
  logic wr_ctrl, wr_load, wr_cmd, stop_cmd, ack_cmd, gate_open_now;

  // Sync pair, third stage for edge detect
  assign lvl = sync_r[1];
  assign rise = sync_r[1] & ~sync_r[2];
  assign fall = ~sync_r[1] & sync_r[2];
  assign edge_hit = (edge_r == capture_pkg::EDGE_RISE) ? rise :
                    (edge_r == capture_pkg::EDGE_FALL) ? fall :
                    (rise | fall);

  assign wr_ctrl = wr && addr == capture_pkg::ADDR_CTRL;
  assign wr_load = wr && addr == capture_pkg::ADDR_LOAD;
  assign wr_cmd = wr && addr == capture_pkg::ADDR_CMD;
  assign stop_cmd = wr_cmd & wdata[capture_pkg::CMD_STOP];
  assign ack_cmd = wr_cmd & wdata[capture_pkg::CMD_IRQ_ACK];
  assign gate_open_now = wr_ctrl & wdata[capture_pkg::CTRL_GATE] & ~gate_r;

  // Internal 1 MHz time base for interval mode
  assign tick = (tb_cnt_r == 5'(capture_pkg::TBASE_DIV - 1));
  // Edges capture only after the gate was once set and not stopped
  assign capture = edge_hit & armed_r & ~stopped_r;
  assign run = gate_r & ~stopped_r;

  always_comb
  begin
    count_nxt = count_r;
    latch_nxt = latch_r;
    if (mode_r == capture_pkg::MODE_INTERVAL)
    begin
      if (capture)
      begin
        // A tick in the capture cycle opens the next interval
        latch_nxt = count_r;
        count_nxt = tick ? 32'h0000_0001 : 32'h0000_0000;
      end
      else if (run && tick)
        count_nxt = count_r + 32'h0000_0001;
    end
    else if (mode_r == capture_pkg::MODE_LATCH)
    begin
      if (gate_open_now)
        count_nxt = load_r;
      else if (run && count_pulse)
        count_nxt = count_r + 32'h0000_0001;
      if (capture)
        latch_nxt = count_r;
    end
    else
    begin
      if (capture)
      begin
        latch_nxt = count_r;
        count_nxt = load_r;
      end
      else if (run && count_pulse)
        count_nxt = count_r + 32'h0000_0001;
    end
  end

  assign rdata_nxt = !rd ? 32'h0000_0000 :
    (addr == capture_pkg::ADDR_CTRL) ?
      {26'h0, irq_en_r, mode_r, edge_r, gate_r} :
    (addr == capture_pkg::ADDR_LOAD) ? load_r :
    (addr == capture_pkg::ADDR_LATCH) ? latch_r :
    (addr == capture_pkg::ADDR_COUNT) ? count_r :
    (addr == capture_pkg::ADDR_STATUS) ?
      {27'h0, armed_r, lost_r, irq_r, stopped_r, lvl} :
    32'h0000_0000;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_r <= 3'h0;
      tb_cnt_r <= 5'h00;
      count_r <= capture_pkg::COUNT_RST;
      latch_r <= capture_pkg::LATCH_RST;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      sync_r <= {sync_r[1:0], capture_trigger_input};
      tb_cnt_r <= tick ? 5'h00 : tb_cnt_r + 5'h01;
      count_r <= count_nxt;
      latch_r <= latch_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      gate_r <= 1'b0;
      edge_r <= 2'h0;
      mode_r <= 2'h0;
      irq_en_r <= 1'b0;
      load_r <= capture_pkg::LOAD_RST;
    end
    else
    begin
      if (stop_cmd)
        gate_r <= 1'b0;
      else if (wr_ctrl)
      begin
        gate_r <= wdata[capture_pkg::CTRL_GATE];
        edge_r <= wdata[capture_pkg::CTRL_EDGE_LO +: 2];
        mode_r <= wdata[capture_pkg::CTRL_MODE_LO +: 2];
        irq_en_r <= wdata[capture_pkg::CTRL_IRQ_EN];
      end
      if (wr_load)
        load_r <= wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      stopped_r <= 1'b0;
      armed_r <= 1'b0;
      irq_r <= 1'b0;
      lost_r <= 1'b0;
      diag_r <= 1'b0;
    end
    else
    begin
      if (stop_cmd)
      begin
        stopped_r <= 1'b1;
        armed_r <= 1'b0;
      end
      else if (gate_open_now)
      begin
        stopped_r <= 1'b0;
        armed_r <= 1'b1;
      end
      if (capture && irq_en_r)
        irq_r <= 1'b1;
      else if (ack_cmd)
        irq_r <= 1'b0;
      if (capture && irq_en_r && irq_r && !ack_cmd)
        lost_r <= 1'b1;
      else if (ack_cmd)
        lost_r <= 1'b0;
      diag_r <= capture && irq_en_r && irq_r && !ack_cmd;
    end
  end

  assign rdata = rdata_r;
  assign irq = irq_r;
  assign diag_irq = diag_r;
endmodule
`default_nettype wire

// ---- rtl/capture_pkg.sv ----
package capture_pkg;
  localparam int COUNT_W = 32;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] LATCH_RST = 32'h0000_0000;
  localparam logic [31:0] LOAD_RST = 32'h0000_0000;
  localparam int CLK_HZ = 20000000;
  localparam int TBASE_HZ = 1000000;
  localparam int TBASE_DIV = CLK_HZ / TBASE_HZ;
  localparam int EDGE_GAP_MS = 1;
  localparam int EDGE_GAP_CYC = CLK_HZ / 1000 * EDGE_GAP_MS;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_LOAD = 4'h1;
  localparam logic [3:0] ADDR_LATCH = 4'h2;
  localparam logic [3:0] ADDR_COUNT = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CMD = 4'h5;
  localparam int CTRL_GATE = 0;
  localparam int CTRL_EDGE_LO = 1;
  localparam int CTRL_MODE_LO = 3;
  localparam int CTRL_IRQ_EN = 5;
  localparam int CMD_STOP = 0;
  localparam int CMD_IRQ_ACK = 1;
  localparam int ST_LEVEL = 0;
  localparam int ST_STOPPED = 1;
  localparam int ST_IRQ = 2;
  localparam int ST_LOST = 3;
  localparam int ST_ARMED = 4;
  typedef enum logic [1:0]
  {
    EDGE_RISE = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_BOTH = 2'h2
  } edge_sel_t;
  typedef enum logic [1:0]
  {
    MODE_RETRIG = 2'h0,
    MODE_LATCH = 2'h1,
    MODE_INTERVAL = 2'h2
  } mode_t;
endpackage

// ---- verification/capture_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module capture_props
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic capture_trigger_input,
  input wire logic count_pulse,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic irq,
  input wire logic diag_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("rdata outside read");
  a_unmapped_zero: assert property ($past(rd) && $past(addr) > 4'h5
    |-> rdata == 32'h0) else $error("unmapped read");
  a_status_rsvd: assert property ($past(rd) &&
    $past(addr) == capture_pkg::ADDR_STATUS |-> rdata[31:5] == 27'h0)
    else $error("status spare bits");
  a_level_flag: assert property ($past(rd) &&
    $past(addr) == capture_pkg::ADDR_STATUS && $stable(capture_trigger_input)
    && $past(capture_trigger_input, 4) == capture_trigger_input
    |-> rdata[0] == capture_trigger_input) else $error("level flag");
  a_diag_pulse: assert property (diag_irq |=> !diag_irq)
    else $error("diag too long");
  a_diag_pending: assert property (diag_irq |-> $past(irq))
    else $error("diag without pending");
  a_diag_keeps: assert property (diag_irq |-> irq)
    else $error("irq lost on diag");
  a_irq_hold: assert property (irq && !wr |=> irq)
    else $error("irq dropped");
endmodule
bind counter_latch_retrigger_capture capture_props capture_props_inst
  (.clk_sys, .nrst, .capture_trigger_input, .count_pulse, .addr, .wdata,
  .wr, .rd, .rdata, .irq, .diag_irq);
`default_nettype wire

// ---- verification/pulse_source.sv ----
`timescale 1ns/100ps
`default_nettype none
module pulse_source
(
  input wire logic clk_sys,
  output logic trig
);
  int cyc = 0;
  int last_q = -capture_pkg::EDGE_GAP_CYC;
  initial trig = 1'b0;
  always @(posedge clk_sys)
    cyc <= cyc + 1;
  // Qualifying edges keep at least the minimum spacing from the last one
  task automatic toggle(input bit qual);
    @(posedge clk_sys);
    while (qual && cyc - last_q < capture_pkg::EDGE_GAP_CYC)
      @(posedge clk_sys);
    trig <= ~trig;
    if (qual)
      last_q = cyc;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ---- verification/counter_latch_retrigger_capture_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module counter_latch_retrigger_capture_bench;
  logic clk_sys = 1'b0, nrst = 1'b0, count_pulse = 1'b0, wr = 1'b0;
  logic rd = 1'b0, trig, irq, diag_irq;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  int n_mismatch = 0, checks = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  pulse_source pulse_source_inst (.clk_sys(clk_sys), .trig(trig));
  counter_latch_retrigger_capture counter_latch_retrigger_capture_inst
    (.clk_sys(clk_sys), .nrst(nrst), .capture_trigger_input(trig),
    .count_pulse(count_pulse), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .diag_irq(diag_irq));
  task automatic end_sim();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e,
    input logic [31:0] m);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic pulses(input int n);
    repeat (n) @(posedge clk_sys) count_pulse <= 1'b1;
    @(posedge clk_sys);
    count_pulse <= 1'b0;
  endtask
  // Retrigger on both edges with interrupt enabled
  task automatic t_retrig();
    wr_reg(capture_pkg::ADDR_LOAD, 32'h55);
    wr_reg(capture_pkg::ADDR_CTRL, 32'h25);
    rd_chk(capture_pkg::ADDR_COUNT, 32'h0, '1);
    pulse_source_inst.toggle(1'b1);
    rd_chk(capture_pkg::ADDR_LATCH, 32'h0, '1);
    rd_chk(capture_pkg::ADDR_COUNT, 32'h55, '1);
    rd_chk(capture_pkg::ADDR_STATUS, 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    pulses(3);
    wr_reg(capture_pkg::ADDR_CTRL, 32'h24);
    pulses(1);
    rd_chk(capture_pkg::ADDR_COUNT, 32'h58, '1);
    pulse_source_inst.toggle(1'b1);
    rd_chk(capture_pkg::ADDR_LATCH, 32'h58, '1);
    rd_chk(capture_pkg::ADDR_COUNT, 32'h55, '1);
    rd_chk(capture_pkg::ADDR_STATUS, 32'h8, 32'h8);
    wr_reg(capture_pkg::ADDR_CTRL, 32'h25);
    pulses(1);
    rd_chk(capture_pkg::ADDR_COUNT, 32'h56, '1);
    wr_reg(capture_pkg::ADDR_CMD, 32'h2);
    #1 chk({31'h0, irq}, 32'h0);
  endtask
  // Latch-only, then gate stop blocks capture
  task automatic t_latch();
    wr_reg(capture_pkg::ADDR_CTRL, 32'h2c);
    wr_reg(capture_pkg::ADDR_CTRL, 32'h2d);
    rd_chk(capture_pkg::ADDR_COUNT, 32'h55, '1);
    pulses(2);
    pulse_source_inst.toggle(1'b1);
    rd_chk(capture_pkg::ADDR_LATCH, 32'h57, '1);
    rd_chk(capture_pkg::ADDR_COUNT, 32'h57, '1);
    wr_reg(capture_pkg::ADDR_CTRL, 32'h2c);
    wr_reg(capture_pkg::ADDR_CTRL, 32'h2d);
    rd_chk(capture_pkg::ADDR_COUNT, 32'h55, '1);
    pulses(1);
    wr_reg(capture_pkg::ADDR_CMD, 32'h1);
    pulse_source_inst.toggle(1'b0);
    rd_chk(capture_pkg::ADDR_LATCH, 32'h57, '1);
  endtask
  // Interval timing between falling edges; rising edges are ignored
  task automatic t_interval();
    wr_reg(capture_pkg::ADDR_CTRL, 32'h13);
    pulse_source_inst.toggle(1'b0);
    pulse_source_inst.toggle(1'b1);
    pulse_source_inst.toggle(1'b0);
    rd_chk(capture_pkg::ADDR_STATUS, 32'h1, 32'h1);
    pulse_source_inst.toggle(1'b1);
    rd_chk(capture_pkg::ADDR_LATCH, 32'h3e8, '1);
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 85000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_retrig();
    t_latch();
    t_interval();
    end_sim();
  end
endmodule
`default_nettype wire
